/* design/pwcw_device.sv */
// device end: configuration registers, window control, pulse output, reseed gating
//
// Added by the designer: strobed register access.
`include "pwcw_consts.svh"
module pwcw_device #(
    parameter int unsigned PULSE_PERIOD_CYC = `PWCW_PULSE_PERIOD_CYC,
    parameter int unsigned TIMEOUT_UNIT_CYC = `PWCW_TIMEOUT_UNIT_CYC
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    pwcw_link_if.dev         link,
    input  wire logic        event_ready,
    input  wire logic [2:0]  halt_ui_timeout,
    input  wire logic [2:0]  halt_release_timeout,
    input  wire logic [2:0]  other_reseed,
    output logic             general_pin_three,
    output logic [2:0]       reseed_req_q,
    output logic             window_open_q
);
    import pwcw_pkg::*;
    pwcw_byte_type power_settings_q;
    pwcw_byte_type pulse_duty_value_q;
    pwcw_byte_type ready_window_timeout_q;
    pwcw_byte_type serial_window_settings_q;
    pwcw_byte_type reseed_channel_enables_q;
    pwcw_byte_type rdata_q;
    pwcw_byte_type rdata_d;
    pwcw_win_type  win_q;
    pwcw_win_type  win_d;
    logic [23:0]   linger_q;
    logic [23:0]   linger_d;
    logic [23:0]   linger_load;
    logic [31:0]   linger_prod;
    logic          sel_power;
    logic          sel_duty;
    logic          sel_timeout;
    logic          sel_serial;
    logic          sel_reseed;
    logic          stop_inhibit;
    logic          pulse_enable;
    logic [2:0]    halt_reseed;
    logic          wr_power;
    logic          wr_duty;
    logic          wr_timeout;
    logic          wr_serial;
    logic          wr_reseed;
    logic          stop_lingers;
    logic          stop_closes;
    logic          linger_done;
    logic          reseed_channel_zero;
    logic          reseed_channel_one;
    logic          reseed_channel_two;
    logic [2:0]    reseed_gate;

    // address decode
    assign sel_power    = link.reg_addr == `PWCW_OFS_POWER_SETTINGS;
    assign sel_duty     = link.reg_addr == `PWCW_OFS_PULSE_DUTY;
    assign sel_timeout  = link.reg_addr == `PWCW_OFS_READY_TIMEOUT;
    assign sel_serial   = link.reg_addr == `PWCW_OFS_SERIAL_SETTINGS;
    assign sel_reseed   = link.reg_addr == `PWCW_OFS_RESEED_ENABLES;
    assign stop_inhibit = serial_window_settings_q[`PWCW_BIT_STOP_INHIBIT];
    assign pulse_enable = power_settings_q[`PWCW_BIT_PULSE_ENABLE];
    assign stop_lingers = link.bus_stop && stop_inhibit;
    assign stop_closes  = link.bus_stop && !stop_inhibit;
    assign linger_done  = linger_q == 24'h0;

    // one-cycle write enables per register
    assign wr_power     = link.reg_wr && sel_power;
    assign wr_duty      = link.reg_wr && sel_duty;
    assign wr_timeout   = link.reg_wr && sel_timeout;
    assign wr_serial    = link.reg_wr && sel_serial;
    assign wr_reseed    = link.reg_wr && sel_reseed;

    // unmapped addresses read as zero, reserved bits read as zero
    assign rdata_d = sel_power   ? power_settings_q :
                     sel_duty    ? pulse_duty_value_q :
                     sel_timeout ? ready_window_timeout_q :
                     sel_serial  ? serial_window_settings_q :
                     sel_reseed  ? reseed_channel_enables_q : 8'h00;

    // register writes; only documented writable bits are stored
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            power_settings_q         <= `PWCW_RST_POWER_SETTINGS;
            pulse_duty_value_q       <= `PWCW_RST_PULSE_DUTY;
            ready_window_timeout_q   <= `PWCW_RST_READY_TIMEOUT;
            serial_window_settings_q <= `PWCW_RST_SERIAL_SETTINGS;
            reseed_channel_enables_q <= `PWCW_RST_RESEED_ENABLES;
        end
        else
        begin
            if (wr_power)
                power_settings_q <= link.reg_wdata;
            if (wr_duty)
                pulse_duty_value_q <= link.reg_wdata;
            if (wr_timeout)
                ready_window_timeout_q <= link.reg_wdata;
            if (wr_serial)
                serial_window_settings_q <= link.reg_wdata & `PWCW_MASK_SERIAL_SETTINGS;
            if (wr_reseed)
                reseed_channel_enables_q <= link.reg_wdata & `PWCW_MASK_RESEED;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rdata_q <= 8'h00;
        else if (link.reg_rd)
            rdata_q <= rdata_d;
        else
            rdata_q <= 8'h00;
    end
    assign link.reg_rdata = rdata_q;

    // linger time after a stop is value times the 0.32 ms unit
    assign linger_prod = 32'(ready_window_timeout_q) * 32'(TIMEOUT_UNIT_CYC);
    assign linger_load = linger_prod[23:0];

    // communication window control
    always_comb
    begin
        win_d    = win_q;
        linger_d = linger_q;
        unique case (win_q)
            WIN_CLOSED:
            begin
                if (event_ready)
                    win_d = WIN_OPEN;
            end
            WIN_OPEN:
            begin
                if (link.bus_stop)
                begin
                    if (stop_inhibit)
                    begin
                        win_d    = WIN_LINGER;
                        linger_d = linger_load;
                    end
                    else
                        win_d = WIN_CLOSED;
                end
            end
            WIN_LINGER:
            begin
                // a new stop restarts the timeout, or closes at once if the inhibit was cleared
                if (link.bus_start)
                    win_d = WIN_OPEN;
                else if (stop_lingers)
                    linger_d = linger_load;
                else if (stop_closes)
                    win_d = WIN_CLOSED;
                else if (linger_done)
                    win_d = WIN_CLOSED;
                else
                    linger_d = linger_q - 24'h1;
            end
            default:
                win_d = WIN_CLOSED;
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            win_q         <= WIN_CLOSED;
            linger_q      <= 24'h0;
            window_open_q <= 1'b0;
        end
        else
        begin
            win_q         <= win_d;
            linger_q      <= linger_d;
            window_open_q <= win_d != WIN_CLOSED;
        end
    end
    assign link.window_open = window_open_q;

    // enables gate only the two halt-timeout reseed sources
    assign reseed_channel_zero = reseed_channel_enables_q[0];
    assign reseed_channel_one  = reseed_channel_enables_q[1];
    assign reseed_channel_two  = reseed_channel_enables_q[2];
    assign reseed_gate         = {reseed_channel_two, reseed_channel_one, reseed_channel_zero};
    for (genvar ch = 0; ch < 3; ch++)
    begin : g_reseed_gate
        assign halt_reseed[ch] = (halt_ui_timeout[ch] | halt_release_timeout[ch]) & reseed_gate[ch];
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            reseed_req_q <= 3'h0;
        else
            reseed_req_q <= halt_reseed | other_reseed;
    end

    pwcw_pulse_gen #(
        .PERIOD_CYC (PULSE_PERIOD_CYC)
    ) i_pwcw_pulse_gen (
        .clk     (clk),
        .nrst    (nrst),
        .enable  (pulse_enable),
        .duty    (pulse_duty_value_q),
        .pulse_q (general_pin_three)
    );
endmodule : pwcw_device

/* design/pwcw_consts.svh */
// constants for the pulse duty, window timeout and reseed configuration bank
// Behaviour
// - duty percent equals (value plus one)/256
// - fixed 1 kHz pulse on pin three
// - pulse appears only with output-enable bit set
// - window timeout equals value times 0.32 ms
// - stop closes window when inhibit clear
// - inhibit set: close only without restart in time
// - host keeps settings bit zero at one
// - host keeps settings bits six..one cleared
// - three reseed enables, bits two..zero, reset on
// - enables gate only halt-timeout reseeds
`ifndef PWCW_CONSTS_SVH
`define PWCW_CONSTS_SVH
`define PWCW_OFS_POWER_SETTINGS   8'hd2
`define PWCW_OFS_PULSE_DUTY       8'hd8
`define PWCW_OFS_READY_TIMEOUT    8'hd9
`define PWCW_OFS_SERIAL_SETTINGS  8'hda
`define PWCW_OFS_RESEED_ENABLES   8'hdb
`define PWCW_RST_POWER_SETTINGS   8'h00
`define PWCW_RST_PULSE_DUTY       8'h00
`define PWCW_RST_READY_TIMEOUT    8'h20
`define PWCW_RST_SERIAL_SETTINGS  8'h01
`define PWCW_RST_RESEED_ENABLES   8'h07
`define PWCW_BIT_PULSE_ENABLE     7
`define PWCW_BIT_STOP_INHIBIT     7
`define PWCW_BIT_SETTINGS_KEEP    0
`define PWCW_MASK_SERIAL_SETTINGS 8'h81
`define PWCW_MASK_RESEED          8'h07
`define PWCW_DUTY_STEPS           256
`define PWCW_CLK_PERIOD_NS        10
`define PWCW_PULSE_PERIOD_NS      1000000
`define PWCW_PULSE_PERIOD_CYC     (`PWCW_PULSE_PERIOD_NS / `PWCW_CLK_PERIOD_NS)
`define PWCW_TIMEOUT_UNIT_NS      320000
`define PWCW_TIMEOUT_UNIT_CYC     (`PWCW_TIMEOUT_UNIT_NS / `PWCW_CLK_PERIOD_NS)
`define PWCW_HOST_OFS_TARGET      4'h0
`define PWCW_HOST_OFS_WDATA       4'h1
`define PWCW_HOST_OFS_COMMAND     4'h2
`define PWCW_HOST_OFS_STATUS      4'h3
`define PWCW_HOST_OFS_RDATA       4'h4
`define PWCW_CMD_WRITE            0
`define PWCW_CMD_READ             1
`define PWCW_CMD_START            2
`define PWCW_CMD_STOP             3
`endif

/* design/pwcw_pkg.sv */
// types shared by both ends of the configuration link
package pwcw_pkg;
    typedef logic [7:0] pwcw_byte_type;
    typedef enum logic [1:0] {
        WIN_CLOSED,
        WIN_OPEN,
        WIN_LINGER
    } pwcw_win_type;
endpackage : pwcw_pkg

/* design/pwcw_link_if.sv */
// link between the serial host end and the device register bank
interface pwcw_link_if (
    input wire logic clk
);
    import pwcw_pkg::*;
    pwcw_byte_type reg_addr;
    pwcw_byte_type reg_wdata;
    pwcw_byte_type reg_rdata;
    logic          reg_wr;
    logic          reg_rd;
    logic          bus_start;
    logic          bus_stop;
    logic          window_open;
    modport dev (
        input  reg_addr,
        input  reg_wdata,
        input  reg_wr,
        input  reg_rd,
        input  bus_start,
        input  bus_stop,
        output reg_rdata,
        output window_open
    );
    modport host (
        output reg_addr,
        output reg_wdata,
        output reg_wr,
        output reg_rd,
        output bus_start,
        output bus_stop,
        input  reg_rdata,
        input  window_open
    );
endinterface : pwcw_link_if

/* design/pwcw_pulse_gen.sv */
// fixed-period pulse generator with 256-step duty
`include "pwcw_consts.svh"
module pwcw_pulse_gen #(
    parameter int unsigned PERIOD_CYC = `PWCW_PULSE_PERIOD_CYC
) (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       enable,
    input  wire logic [7:0] duty,
    output logic            pulse_q
);
    import pwcw_pkg::*;
    localparam logic [31:0] PERIOD_W = 32'(PERIOD_CYC);
    logic [31:0] phase_q;
    logic [31:0] phase_d;
    logic [31:0] high_cycles;
    logic [40:0] high_prod;
    // high time is (duty+1) of 256 steps of one period
    assign high_prod   = 41'({24'h0, duty} + 32'h1) * 41'(PERIOD_W);
    assign high_cycles = high_prod[39:8];
    assign phase_d     = (phase_q == PERIOD_W - 32'h1) ? 32'h0 : phase_q + 32'h1;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            phase_q <= 32'h0;
            pulse_q <= 1'b0;
        end
        else
        begin
            phase_q <= phase_d;
            pulse_q <= enable && (phase_q < high_cycles);
        end
    end
endmodule : pwcw_pulse_gen

/* design/pwcw_host.sv */
// host end: software command registers driving the configuration link
`include "pwcw_consts.svh"
module pwcw_host (
    input  wire logic       clk,
    input  wire logic       nrst,
    pwcw_link_if.host       link,
    input  wire logic [3:0] sw_addr,
    input  wire logic [7:0] sw_wdata,
    input  wire logic       sw_wr,
    input  wire logic       sw_rd,
    output logic [7:0]      sw_rdata_q
);
    import pwcw_pkg::*;
    pwcw_byte_type target_q;
    pwcw_byte_type wdata_q;
    pwcw_byte_type last_rdata_q;
    pwcw_byte_type link_wdata;
    pwcw_byte_type sw_rdata_d;
    logic          read_pending_q;
    logic          read_valid_q;
    logic          cmd_wr;
    logic          to_settings;

    assign cmd_wr      = sw_wr && (sw_addr == `PWCW_HOST_OFS_COMMAND);
    assign to_settings = target_q == `PWCW_OFS_SERIAL_SETTINGS;
    // settings writes keep bit zero set and reserved bits clear
    assign link_wdata  = to_settings ?
                         ((wdata_q & `PWCW_MASK_SERIAL_SETTINGS) | 8'h01) : wdata_q;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            target_q <= 8'h00;
            wdata_q  <= 8'h00;
        end
        else if (sw_wr)
        begin
            if (sw_addr == `PWCW_HOST_OFS_TARGET)
                target_q <= sw_wdata;
            if (sw_addr == `PWCW_HOST_OFS_WDATA)
                wdata_q <= sw_wdata;
        end
    end

    // one command write gives one-cycle link strobes in the next cycle
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            link.reg_addr  <= 8'h00;
            link.reg_wdata <= 8'h00;
            link.reg_wr    <= 1'b0;
            link.reg_rd    <= 1'b0;
            link.bus_start <= 1'b0;
            link.bus_stop  <= 1'b0;
        end
        else
        begin
            link.reg_addr  <= target_q;
            link.reg_wdata <= link_wdata;
            link.reg_wr    <= cmd_wr && sw_wdata[`PWCW_CMD_WRITE];
            link.reg_rd    <= cmd_wr && sw_wdata[`PWCW_CMD_READ];
            link.bus_start <= cmd_wr && sw_wdata[`PWCW_CMD_START];
            link.bus_stop  <= cmd_wr && sw_wdata[`PWCW_CMD_STOP];
        end
    end

    // capture device read data one cycle after the link read strobe
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            read_pending_q <= 1'b0;
            read_valid_q   <= 1'b0;
            last_rdata_q   <= 8'h00;
        end
        else
        begin
            read_pending_q <= link.reg_rd;
            if (read_pending_q)
            begin
                last_rdata_q <= link.reg_rdata;
                read_valid_q <= 1'b1;
            end
            else if (sw_rd && (sw_addr == `PWCW_HOST_OFS_RDATA))
                read_valid_q <= 1'b0;
        end
    end

    assign sw_rdata_d = (sw_addr == `PWCW_HOST_OFS_TARGET) ? target_q :
                        (sw_addr == `PWCW_HOST_OFS_WDATA)  ? wdata_q :
                        (sw_addr == `PWCW_HOST_OFS_STATUS) ? {6'h0, read_valid_q, link.window_open} :
                        (sw_addr == `PWCW_HOST_OFS_RDATA)  ? last_rdata_q : 8'h00;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            sw_rdata_q <= 8'h00;
        else
            sw_rdata_q <= sw_rd ? sw_rdata_d : 8'h00;
    end
endmodule : pwcw_host

/* verif/pwcw_assertions.sv */
// concurrent checks on the link between the host end and the device bank
`include "pwcw_consts.svh"
module pwcw_checker #(
    parameter int unsigned TIMEOUT_UNIT_CYC = `PWCW_TIMEOUT_UNIT_CYC
) (
    input wire logic                    clk,
    input wire logic                    nrst,
    input wire pwcw_pkg::pwcw_byte_type reg_addr,
    input wire pwcw_pkg::pwcw_byte_type reg_wdata,
    input wire pwcw_pkg::pwcw_byte_type reg_rdata,
    input wire logic                    reg_wr,
    input wire logic                    reg_rd,
    input wire logic                    bus_start,
    input wire logic                    bus_stop,
    input wire logic                    window_open
);
    timeunit 1ns;
    timeprecision 1ps;
    import pwcw_pkg::*;
    logic        inh_q;
    logic        armed_q;
    logic [7:0]  tmo_q;
    logic [23:0] cnt_q;
    logic [31:0] lim;
    // shadow of inhibit and timeout, and cycles since the last stop while lingering
    assign lim = tmo_q * TIMEOUT_UNIT_CYC;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            inh_q   <= 1'b0;
            tmo_q   <= 8'h20;
            armed_q <= 1'b0;
            cnt_q   <= 24'h0;
        end
        else
        begin
            if (reg_wr && reg_addr == 8'hda)
                inh_q <= reg_wdata[7];
            if (reg_wr && reg_addr == 8'hd9)
                tmo_q <= reg_wdata;
            cnt_q   <= bus_stop ? 24'h0 : cnt_q + 24'h1;
            armed_q <= window_open && !bus_start && (bus_stop ? inh_q : armed_q);
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    stop_close_a: assert property (!inh_q && window_open && bus_stop && !bus_start |=> !window_open)
        else $error("stop did not close the window");
    stop_hold_a: assert property (inh_q && window_open && bus_stop |=> window_open)
        else $error("stop closed an inhibited window");
    linger_hold_a: assert property (armed_q && cnt_q <= lim |-> window_open)
        else $error("window closed before its timeout");
    linger_close_a: assert property (armed_q && !bus_start && cnt_q == lim |=> !window_open)
        else $error("window outlived its timeout");
    keep_bit_a: assert property (reg_wr && reg_addr == 8'hda |-> reg_wdata[0])
        else $error("settings write with bit zero clear");
    reserved_bits_a: assert property (reg_wr && reg_addr == 8'hda |-> reg_wdata[6:1] == 6'h00)
        else $error("settings write with reserved bits set");
    settings_rd_a: assert property (reg_rd && reg_addr == 8'hda |=> reg_rdata == {$past(inh_q), 7'h01})
        else $error("settings read wrong");
    reseed_rd_a: assert property (reg_rd && reg_addr == 8'hdb |=> reg_rdata[7:3] == 5'h00)
        else $error("reseed enables read upper bits");
    unmapped_rd_a: assert property (reg_rd && !(reg_addr inside {8'hd2, [8'hd8:8'hdb]}) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    cover property (armed_q && cnt_q == lim);
    cover property (armed_q && bus_start);
    cover property (reg_rd && reg_addr == 8'hda);
endmodule : pwcw_checker

/* verif/test_pwm_comm_window_config.sv */
// self-checking bench for the configuration bank and its host end
module test_pwm_comm_window_config;
    timeunit 1ns;
    timeprecision 1ps;
    import pwcw_pkg::*;
    localparam int unsigned PER  = 512;
    localparam int unsigned UNIT = 4;
    localparam logic [7:0]  ADR [6] = '{8'hd2, 8'hd8, 8'hd9, 8'hda, 8'hdb, 8'hd7};
    localparam logic [7:0]  RST [6] = '{8'h00, 8'h00, 8'h20, 8'h01, 8'h07, 8'h00};
    logic        clk;
    logic        nrst;
    logic        event_ready;
    logic        sw_wr;
    logic        sw_rd;
    logic        pin;
    logic        win;
    logic [2:0]  ui;
    logic [2:0]  rel;
    logic [2:0]  oth;
    logic [2:0]  req;
    logic [3:0]  sw_addr;
    logic [7:0]  sw_wdata;
    logic [7:0]  rdata;
    logic [7:0]  v;
    logic [7:0]  wv;
    logic [31:0] rnd;
    int          n_errors = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          k;
    int          hi;
    pwcw_link_if link (.clk(clk));
    pwcw_device #(.PULSE_PERIOD_CYC(PER), .TIMEOUT_UNIT_CYC(UNIT)) i_pwcw_device (.clk(clk), .nrst(nrst),
        .link(link), .event_ready(event_ready), .halt_ui_timeout(ui), .halt_release_timeout(rel),
        .other_reseed(oth), .general_pin_three(pin), .reseed_req_q(req), .window_open_q(win));
    pwcw_host i_pwcw_host (.clk(clk), .nrst(nrst), .link(link), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
        .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata_q(rdata));
    pwcw_checker #(.TIMEOUT_UNIT_CYC(UNIT)) i_pwcw_checker (.clk(clk), .nrst(nrst), .reg_addr(link.reg_addr),
        .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata), .reg_wr(link.reg_wr), .reg_rd(link.reg_rd),
        .bus_start(link.bus_start), .bus_stop(link.bus_stop), .window_open(link.window_open));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [15:0] rb(input logic [7:0] a, input logic [7:0] d);
        if (a == 8'hda)
            return {8'h0, d[7], 7'h01};
        if (a == 8'hdb)
            return {13'h0, d[2:0]};
        return {8'h0, d};
    endfunction : rb
    function automatic logic [15:0] exp_req(input logic [31:0] r, input logic [7:0] en);
        return {13'h0, ((r[2:0] | r[5:3]) & en[2:0]) | r[8:6]};
    endfunction : exp_req
    function automatic logic [15:0] exp_hi(input logic [7:0] d, input logic en);
        return en ? 16'((int'(d) + 1) * PER / 256) : 16'h0;
    endfunction : exp_hi
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_n
    // one software cycle; a read leaves its data in v
    task automatic sw_op(input logic wr, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        sw_wr    <= wr;
        sw_rd    <= !wr;
        sw_addr  <= a;
        sw_wdata <= d;
        @(posedge clk);
        sw_wr    <= 1'b0;
        sw_rd    <= 1'b0;
        #1;
        v = rdata;
    endtask : sw_op
    task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
        sw_op(1'b1, 4'h0, a);
        sw_op(1'b1, 4'h1, d);
        sw_op(1'b1, 4'h2, 8'h01);
        wait_n(3);
    endtask : dev_wr
    task automatic dev_rd(input logic [7:0] a);
        sw_op(1'b1, 4'h0, a);
        sw_op(1'b1, 4'h2, 8'h02);
        wait_n(3);
        sw_op(1'b0, 4'h4, 8'h00);
    endtask : dev_rd
    task automatic open_win();
        @(posedge clk);
        event_ready <= 1'b1;
        @(posedge clk);
        event_ready <= 1'b0;
        wait_n(2);
        chk("window opens", {15'h0, win}, 16'h1);
    endtask : open_win
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 12000)
        begin
            n_errors++;
            close_out();
        end
    end
    initial
    begin
        nrst        = 1'b0;
        event_ready = 1'b0;
        sw_wr       = 1'b0;
        sw_rd       = 1'b0;
        sw_addr     = 4'h0;
        sw_wdata    = 8'h00;
        ui          = 3'h0;
        rel         = 3'h0;
        oth         = 3'h0;
        rnd         = 32'h5a91;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        for (k = 0; k < 6; k++)
        begin
            dev_rd(ADR[k]);
            chk("reset value", {8'h0, v}, {8'h0, RST[k]});
        end
        $display("reset values done");
        for (k = 0; k < 8; k++)
        begin
            rnd = lfsr(rnd);
            dev_wr(ADR[k % 4 + 1], rnd[7:0]);
            dev_rd(ADR[k % 4 + 1]);
            chk("read back", {8'h0, v}, rb(ADR[k % 4 + 1], rnd[7:0]));
        end
        $display("read back done");
        for (k = 0; k < 12; k++)
        begin
            rnd = lfsr(rnd);
            if (k % 4 == 0)
            begin
                wv = (k == 0) ? 8'hf8 : rnd[15:8];
                dev_wr(8'hdb, wv);
            end
            @(posedge clk);
            ui  <= rnd[2:0];
            rel <= rnd[5:3];
            oth <= rnd[8:6];
            @(posedge clk);
            ui  <= 3'h0;
            rel <= 3'h0;
            oth <= 3'h0;
            #1;
            chk("reseed request", {13'h0, req}, exp_req(rnd, wv));
        end
        $display("reseed gating done");
        dev_wr(8'hd2, 8'h80);
        for (k = 0; k < 5; k++)
        begin
            rnd = lfsr(rnd);
            wv  = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : rnd[7:0];
            if (k == 4)
                dev_wr(8'hd2, 8'h00);
            dev_wr(8'hd8, wv);
            wait_n(PER);
            hi = 0;
            repeat (PER)
            begin
                wait_n(1);
                hi += int'(pin === 1'b1);
            end
            chk("pulse high cycles", 16'(hi), exp_hi(wv, k != 4));
        end
        $display("pulse output done");
        dev_wr(8'hd9, 8'h03);
        dev_wr(8'hda, 8'h01);
        open_win();
        sw_op(1'b1, 4'h2, 8'h08);
        wait_n(4);
        chk("stop closes", {15'h0, win}, 16'h0);
        dev_wr(8'hda, 8'h81);
        open_win();
        sw_op(1'b1, 4'h2, 8'h08);
        wait_n(3);
        chk("linger open", {15'h0, win}, 16'h1);
        sw_op(1'b0, 4'h3, 8'h00);
        chk("status while lingering", {8'h0, v}, 16'h0001);
        sw_op(1'b1, 4'h2, 8'h04);
        wait_n(30);
        chk("restart keeps open", {15'h0, win}, 16'h1);
        sw_op(1'b1, 4'h2, 8'h08);
        wait_n(3 * UNIT + 8);
        chk("timeout closes", {15'h0, win}, 16'h0);
        $display("window done");
        close_out();
    end
endmodule : test_pwm_comm_window_config
